// ---- bfs_partner.sv ----
// Far-side model: oscillator, PWM loop, output sense and pull-up
`timescale 1ns/1ps
module bfs_partner #(
  parameter int PERIOD = 8,
  parameter int DUTY = 4
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic hs_on, // high-side command
  input wire logic soft_start_reset, // ramp held in reset
  input wire logic pg_o, // power-good drive level
  input wire logic pg_oe, // power-good pulldown on
  output logic osc_pulse, // cycle start
  output logic pwm_high_req, // loop wants high side
  output logic vout_above_uv, // output up
  output wire logic pg_wire // power-good pin
);
  logic [7:0] phase;
  // Open drain with pull-up: a released pin reads high
  assign pg_wire = pg_oe ? pg_o : 1'b1;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= '0;
      osc_pulse <= 1'b0;
      pwm_high_req <= 1'b0;
      vout_above_uv <= 1'b0;
    end else begin
      phase <= (phase == 8'(PERIOD - 1)) ? 8'h0 : phase + 8'h1;
      osc_pulse <= (phase == 8'h0);
      pwm_high_req <= (phase < 8'(DUTY));
      // Output only rises once the high side has switched, and collapses on ramp reset
      vout_above_uv <= !soft_start_reset && (vout_above_uv || hs_on);
    end
  end
endmodule

// ---- bfs_pkg.sv ----
// Shared constants and types for the buck fault supervisor
package bfs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int BLANK_NS = 80;
  localparam int MIN_OFF_NS = 120;
  localparam int OV_DELAY_NS = 20000;
  localparam int SOFT_START_NS = 1000000;
  localparam int HICCUP_NS = 5000000;
  localparam int BLANK_CYC = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MIN_OFF_CYC = (MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OV_DELAY_CYC = (OV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFT_START_CYC = (SOFT_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HICCUP_CYC = (HICCUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Cycle limits and slope relationship (milli units)
  // ----------------------------------------------------------------
  localparam int OC_CYCLE_LIMIT = 8;
  localparam int SW_SHORT_CYCLE_LIMIT = 3;
  localparam int FSW_KHZ = 2000;
  localparam int SLOPE_GAIN_MILLI = 1400;
  localparam int SLOPE_OFFSET_MILLI = 205;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_FAULTS = 12'h008;
  localparam logic [11:0] REG_COUNT = 12'h00c;
  localparam logic [11:0] REG_SLOPE = 12'h010;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b1;

  // ----------------------------------------------------------------
  // Comparator flag indices
  // ----------------------------------------------------------------
  localparam int F_EN = 0;
  localparam int F_INPUT_LOW_LOCKOUT = 1;
  localparam int F_PCL = 2;
  localparam int F_SEC = 3;
  localparam int F_BOPEN = 4;
  localparam int F_BSHORT = 5;
  localparam int F_OV = 6;
  localparam int F_OT = 7;
  localparam int F_PWM = 8;
  localparam int F_VOK = 9;
  localparam int F_OSC = 10;
  localparam int NUM_FLAGS = 11;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_SOFT = 3'h1,
    ST_RUN = 3'h2,
    ST_HICCUP = 3'h3,
    ST_LATCHED = 3'h4
  } bfs_state_e;

  typedef struct packed {
    logic oc_hiccup;
    logic sw_short;
    logic boot_open;
    logic boot_short;
    logic overvolt;
    logic overtemp;
    logic input_low;
    logic latched;
  } bfs_faults_s;

  typedef struct packed {
    logic [18:0] rsvd;
    logic power_ok_low;
    logic ss_reset;
    logic boot_short;
    logic boot_open;
    logic overtemp;
    logic overvolt;
    logic input_low;
    logic pcl_trip;
    logic ls;
    logic hs;
    logic [2:0] state;
  } bfs_status_s;

endpackage

// ---- bfs_supervisor.sv ----
// Fault supervisor for a synchronous buck regulator with AHB-Lite registers
//
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - Hold disabled while input below lockout
// - Current limit: high off, low on
// - Ignore current limit during turn-on blanking
// - Count overcurrent cycles, fault at limit
// - Retry soft-start every hiccup interval
// - Overcurrent counter frozen during soft-start
// - Recover automatically once overload clears
// - Open bootstrap: power-good low, hiccup
// - Bootstrap short before startup: no switching
// - Bootstrap short after startup latches off
// - Bootstrap short leaves power-good floating
// - Overvoltage: high off, pulse low side
// - Power-good low after overvoltage delay
// - Secondary overcurrent beyond two cycles: high off
// - Switch short: hiccup, retry, auto recover
// - Slope ramp equals 1.4 fsw minus 0.205
// - Overtemperature stops switching, resets soft-start
// - Disable or fault resets soft-start; overvoltage leaves it running
module bfs_supervisor #(
  parameter int HICCUP_CYCLES = bfs_pkg::HICCUP_CYC,
  parameter int SOFT_START_CYCLES = bfs_pkg::SOFT_START_CYC,
  parameter int OC_LIMIT = bfs_pkg::OC_CYCLE_LIMIT,
  parameter int SW_LIMIT = bfs_pkg::SW_SHORT_CYCLE_LIMIT,
  parameter int FSW_KHZ = bfs_pkg::FSW_KHZ,
  parameter int SEQ_W = 24
) (
  input wire logic hclk, // clock, 25 MHz
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write strobe
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // response, always OKAY
  output logic [31:0] hrdata, // read data
  input wire logic enable_pin, // regulator enable
  input wire logic input_low_lockout, // input below lockout level
  input wire logic per_pulse_current_limit, // high-side peak over limit
  input wire logic secondary_current_flag, // very high high-side current
  input wire logic boot_cap_open, // bootstrap capacitor open
  input wire logic boot_cap_short, // bootstrap capacitor shorted
  input wire logic output_overvoltage_guard, // output overvoltage
  input wire logic overtemp_shutdown, // junction too hot
  input wire logic pwm_high_req, // PWM loop asks for high side
  input wire logic vout_above_uv, // output above undervoltage level
  input wire logic osc_pulse, // oscillator clock pulse
  output logic hs_on, // high-side switch command
  output logic ls_on, // low-side switch command
  output logic soft_start_reset, // reset soft-start and error amp
  output logic soft_start_active, // soft-start ramp running
  output logic hiccup_active, // waiting out a hiccup interval
  output logic power_ok_out_o, // power-good pin level when driven
  output logic power_ok_out_oe // power-good pulled low
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    bfs_pkg::bfs_state_e st;
    logic hs;
    logic ls;
    logic pg_oe;
    logic ss_rst;
    logic pcl_trip;
    logic pcl_seen;
    logic sec_seen;
    logic [7:0] oc_cnt;
    logic [7:0] sec_cnt;
    logic osc_d;
    logic ctrl_en;
    bfs_pkg::bfs_faults_s flt;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
  } bfs_top_s;

  localparam bfs_top_s TOP_RST = '{
    st: bfs_pkg::ST_OFF,
    ss_rst: 1'b1,
    ctrl_en: bfs_pkg::CTRL_EN_RST,
    default: '0
  };
  localparam int SLOPE_MILLI =
    (bfs_pkg::SLOPE_GAIN_MILLI * FSW_KHZ) / 1000 - bfs_pkg::SLOPE_OFFSET_MILLI;

  bfs_top_s r;
  bfs_top_s n;
  logic [bfs_pkg::NUM_FLAGS-1:0] raw;
  logic [bfs_pkg::NUM_FLAGS-1:0] fs;
  logic cyc_start;
  logic active;
  logic pcl_ok;
  logic sec_now;
  logic oc_hit;
  logic sw_hit;
  logic go_off;
  logic ov_pg_low;
  logic sw_allow;
  logic bus_acc;
  logic [31:0] rd_word;
  bfs_pkg::bfs_status_s sts;

  // ----------------------------------------------------------------
  // Flag synchronisation
  // ----------------------------------------------------------------
  assign raw[bfs_pkg::F_EN] = enable_pin;
  assign raw[bfs_pkg::F_INPUT_LOW_LOCKOUT] = input_low_lockout;
  assign raw[bfs_pkg::F_PCL] = per_pulse_current_limit;
  assign raw[bfs_pkg::F_SEC] = secondary_current_flag;
  assign raw[bfs_pkg::F_BOPEN] = boot_cap_open;
  assign raw[bfs_pkg::F_BSHORT] = boot_cap_short;
  assign raw[bfs_pkg::F_OV] = output_overvoltage_guard;
  assign raw[bfs_pkg::F_OT] = overtemp_shutdown;
  assign raw[bfs_pkg::F_PWM] = pwm_high_req;
  assign raw[bfs_pkg::F_VOK] = vout_above_uv;
  assign raw[bfs_pkg::F_OSC] = osc_pulse;

  bfs_sync #(.W(bfs_pkg::NUM_FLAGS)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .d(raw),
    .q(fs)
  );

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  bfs_tmr_if #(.W(8)) blank_if ();
  bfs_tmr_if #(.W(8)) offp_if ();
  bfs_tmr_if #(.W(12)) ovd_if ();
  bfs_tmr_if #(.W(SEQ_W)) seq_if ();

  bfs_timer #(.W(8)) u_blank (.hclk(hclk), .hresetn(hresetn), .ce(ce), .t(blank_if));
  bfs_timer #(.W(8)) u_offp (.hclk(hclk), .hresetn(hresetn), .ce(ce), .t(offp_if));
  bfs_timer #(.W(12)) u_ovd (.hclk(hclk), .hresetn(hresetn), .ce(ce), .t(ovd_if));
  bfs_timer #(.W(SEQ_W)) u_seq (.hclk(hclk), .hresetn(hresetn), .ce(ce), .t(seq_if));

  // Blanking restarts on every high-side turn-on
  assign blank_if.load = n.hs & ~r.hs;
  assign blank_if.load_val = 8'(bfs_pkg::BLANK_CYC);
  // One low-side pulse of minimum off-time per switching cycle while in overvoltage
  assign offp_if.load = cyc_start & fs[bfs_pkg::F_OV] & active;
  assign offp_if.load_val = 8'(bfs_pkg::MIN_OFF_CYC);
  // Held loaded while no overvoltage, so it only runs out on a lasting one
  assign ovd_if.load = ~fs[bfs_pkg::F_OV];
  assign ovd_if.load_val = 12'(bfs_pkg::OV_DELAY_CYC);
  assign seq_if.load = (n.st != r.st) &&
    ((n.st == bfs_pkg::ST_SOFT) || (n.st == bfs_pkg::ST_HICCUP));
  assign seq_if.load_val = (n.st == bfs_pkg::ST_HICCUP) ?
    SEQ_W'(HICCUP_CYCLES) : SEQ_W'(SOFT_START_CYCLES);

  // ----------------------------------------------------------------
  // Fault decisions
  // ----------------------------------------------------------------
  assign cyc_start = fs[bfs_pkg::F_OSC] & ~r.osc_d;
  assign active = (r.st == bfs_pkg::ST_SOFT) || (r.st == bfs_pkg::ST_RUN);
  assign pcl_ok = fs[bfs_pkg::F_PCL] & r.hs & blank_if.zero;
  assign sec_now = fs[bfs_pkg::F_SEC] & r.hs;
  assign oc_hit = r.oc_cnt >= 8'(OC_LIMIT);
  assign sw_hit = r.sec_cnt >= 8'(SW_LIMIT);
  assign go_off = ~(fs[bfs_pkg::F_EN] & r.ctrl_en) | fs[bfs_pkg::F_INPUT_LOW_LOCKOUT] |
    fs[bfs_pkg::F_OT] | fs[bfs_pkg::F_BSHORT];
  assign ov_pg_low = fs[bfs_pkg::F_OV] & ovd_if.zero;
  assign bus_acc = hsel & hready & htrans[1];

  always_comb begin
    n = r;
    n.osc_d = fs[bfs_pkg::F_OSC];

    // Sequencer
    if (r.st == bfs_pkg::ST_LATCHED) begin
      n.st = bfs_pkg::ST_LATCHED;
    end else if (fs[bfs_pkg::F_BSHORT] && (r.st == bfs_pkg::ST_RUN)) begin
      n.st = bfs_pkg::ST_LATCHED;
    end else if (go_off) begin
      n.st = bfs_pkg::ST_OFF;
    end else begin
      case (r.st)
        bfs_pkg::ST_OFF: begin
          n.st = bfs_pkg::ST_SOFT;
        end
        bfs_pkg::ST_SOFT: begin
          if (fs[bfs_pkg::F_BOPEN] || sw_hit) begin
            n.st = bfs_pkg::ST_HICCUP;
          end else if (seq_if.zero) begin
            n.st = bfs_pkg::ST_RUN;
          end
        end
        bfs_pkg::ST_RUN: begin
          if (fs[bfs_pkg::F_BOPEN] || oc_hit || sw_hit) begin
            n.st = bfs_pkg::ST_HICCUP;
          end
        end
        bfs_pkg::ST_HICCUP: begin
          if (seq_if.zero) begin
            n.st = bfs_pkg::ST_SOFT;
          end
        end
        default: begin
          n.st = bfs_pkg::ST_OFF;
        end
      endcase
    end
    n.ss_rst = (n.st != bfs_pkg::ST_SOFT) && (n.st != bfs_pkg::ST_RUN);

    // Per-pulse limit holds until the next oscillator pulse; a trip wins
    if (!active) begin
      n.pcl_trip = 1'b0;
      n.pcl_seen = 1'b0;
    end else if (cyc_start) begin
      n.pcl_trip = pcl_ok;
      n.pcl_seen = pcl_ok;
    end else begin
      n.pcl_trip = r.pcl_trip | pcl_ok;
      n.pcl_seen = r.pcl_seen | pcl_ok;
    end

    // Consecutive overcurrent cycles; frozen at zero outside regulation
    if (r.st != bfs_pkg::ST_RUN) begin
      n.oc_cnt = '0;
    end else if (cyc_start) begin
      if (r.pcl_seen | pcl_ok) begin
        n.oc_cnt = oc_hit ? r.oc_cnt : r.oc_cnt + 8'h01;
      end else begin
        n.oc_cnt = '0;
      end
    end

    // Consecutive secondary-detector cycles
    if (!active) begin
      n.sec_cnt = '0;
      n.sec_seen = 1'b0;
    end else if (cyc_start) begin
      if (r.sec_seen | sec_now) begin
        n.sec_cnt = sw_hit ? r.sec_cnt : r.sec_cnt + 8'h01;
      end else begin
        n.sec_cnt = '0;
      end
      n.sec_seen = 1'b0;
    end else begin
      n.sec_seen = r.sec_seen | sec_now;
    end

    // Switch commands; never both on
    sw_allow = ((n.st == bfs_pkg::ST_SOFT) || (n.st == bfs_pkg::ST_RUN)) &&
      !fs[bfs_pkg::F_OV] && !sw_hit;
    n.hs = sw_allow & fs[bfs_pkg::F_PWM] & ~n.pcl_trip;
    if (fs[bfs_pkg::F_OV]) begin
      n.ls = active & ~offp_if.zero;
    end else begin
      n.ls = sw_allow & ~n.hs;
    end

    // Power-good pull-down; floats on any bootstrap short
    if (fs[bfs_pkg::F_BSHORT] || (n.st == bfs_pkg::ST_LATCHED)) begin
      n.pg_oe = 1'b0;
    end else begin
      n.pg_oe = !((n.st == bfs_pkg::ST_RUN) && fs[bfs_pkg::F_VOK] && !ov_pg_low);
    end

    // Bus address phase
    n.wr_pend = bus_acc & hwrite;
    if (bus_acc & hwrite) begin
      n.wr_addr = haddr[11:0];
    end
    if (bus_acc & ~hwrite) begin
      n.rdata = rd_word;
    end

    // Bus data phase
    if (r.wr_pend) begin
      if (r.wr_addr == bfs_pkg::REG_CTRL) begin
        n.ctrl_en = hwdata[bfs_pkg::CTRL_EN_BIT];
      end else if (r.wr_addr == bfs_pkg::REG_FAULTS) begin
        n.flt = r.flt & ~bfs_pkg::bfs_faults_s'(hwdata[7:0]);
      end
    end

    // Sticky records are set after the clear so a new event survives it
    if ((n.st == bfs_pkg::ST_HICCUP) && (r.st != bfs_pkg::ST_HICCUP) && oc_hit) begin
      n.flt.oc_hiccup = 1'b1;
    end
    if (sw_hit) begin
      n.flt.sw_short = 1'b1;
    end
    if (fs[bfs_pkg::F_BOPEN]) begin
      n.flt.boot_open = 1'b1;
    end
    if (fs[bfs_pkg::F_BSHORT]) begin
      n.flt.boot_short = 1'b1;
    end
    if (fs[bfs_pkg::F_OV]) begin
      n.flt.overvolt = 1'b1;
    end
    if (fs[bfs_pkg::F_OT]) begin
      n.flt.overtemp = 1'b1;
    end
    if (fs[bfs_pkg::F_INPUT_LOW_LOCKOUT]) begin
      n.flt.input_low = 1'b1;
    end
    if (n.st == bfs_pkg::ST_LATCHED) begin
      n.flt.latched = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  always_comb begin
    sts = '0;
    sts.state = r.st;
    sts.hs = r.hs;
    sts.ls = r.ls;
    sts.pcl_trip = r.pcl_trip;
    sts.input_low = fs[bfs_pkg::F_INPUT_LOW_LOCKOUT];
    sts.overvolt = fs[bfs_pkg::F_OV];
    sts.overtemp = fs[bfs_pkg::F_OT];
    sts.boot_open = fs[bfs_pkg::F_BOPEN];
    sts.boot_short = fs[bfs_pkg::F_BSHORT];
    sts.ss_reset = r.ss_rst;
    sts.power_ok_low = r.pg_oe;
    if (haddr[11:0] == bfs_pkg::REG_CTRL) begin
      rd_word = {31'h0, r.ctrl_en};
    end else if (haddr[11:0] == bfs_pkg::REG_STATUS) begin
      rd_word = sts;
    end else if (haddr[11:0] == bfs_pkg::REG_FAULTS) begin
      rd_word = {24'h0, r.flt};
    end else if (haddr[11:0] == bfs_pkg::REG_COUNT) begin
      rd_word = {16'h0, r.sec_cnt, r.oc_cnt};
    end else if (haddr[11:0] == bfs_pkg::REG_SLOPE) begin
      rd_word = 32'(SLOPE_MILLI);
    end else begin
      rd_word = 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= TOP_RST;
    end else if (ce) begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Zero wait states: every transfer completes in its first data cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign hs_on = r.hs;
  assign ls_on = r.ls;
  assign soft_start_reset = r.ss_rst;
  assign soft_start_active = (r.st == bfs_pkg::ST_SOFT);
  assign hiccup_active = (r.st == bfs_pkg::ST_HICCUP);
  // Open drain: only ever pulls low
  assign power_ok_out_o = 1'b0;
  assign power_ok_out_oe = r.pg_oe;

endmodule

// ---- bfs_supervisor_monitor.sv ----
// Pin-level checker for the buck fault supervisor
`timescale 1ns/1ps
module bfs_supervisor_monitor #(
  parameter int HICCUP_CYCLES = 20
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // reset, active low
  input wire logic input_low_lockout, // input low
  input wire logic boot_cap_short, // boot short
  input wire logic output_overvoltage_guard, // overvoltage
  input wire logic overtemp_shutdown, // too hot
  input wire logic hs_on, // high side
  input wire logic ls_on, // low side
  input wire logic soft_start_reset, // ramp reset
  input wire logic soft_start_active, // ramp running
  input wire logic hiccup_active, // hiccup wait
  input wire logic power_ok_out_oe // pulldown on
);
  logic [9:0] ov_cnt;
  logic [19:0] hic_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Counters stand in for repetitions too long to unroll
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ov_cnt <= '0;
      hic_cnt <= '0;
    end else begin
      ov_cnt <= !output_overvoltage_guard ? '0 : ov_cnt + {9'h0, ~&ov_cnt};
      hic_cnt <= hiccup_active ? hic_cnt + 20'h1 : '0;
    end
  end
  sequence ov_seen;
    output_overvoltage_guard [*6];
  endsequence
  sequence ls_pulse;
    ls_on [*3] ##1 !ls_on;
  endsequence
  chk_sw_exclusive:
    assert property (!(hs_on && ls_on)) else $error("both switches on");
  chk_low_input:
    assert property (input_low_lockout [*4] |-> !hs_on && !ls_on && soft_start_reset)
    else $error("switching while input low");
  chk_hot_stop:
    assert property (overtemp_shutdown [*4] |-> !hs_on && !ls_on && soft_start_reset)
    else $error("switching while hot");
  chk_boot_float:
    assert property ((boot_cap_short && hresetn) [*4] |-> !power_ok_out_oe && !hs_on && !ls_on)
    else $error("boot short not handled");
  chk_ov_high_off:
    assert property (ov_seen |-> !hs_on) else $error("high side on in overvoltage");
  chk_ov_ls_pulse:
    assert property (ov_seen ##0 $rose(ls_on) |-> ls_pulse)
    else $error("low side pulse width wrong");
  chk_ov_pg_delay:
    assert property (ov_cnt == 10'h1fe && !boot_cap_short |-> power_ok_out_oe)
    else $error("power good not pulled low after delay");
  chk_hiccup_len:
    assert property ($fell(hiccup_active) && soft_start_active |->
      hic_cnt >= HICCUP_CYCLES - 1 && hic_cnt <= HICCUP_CYCLES + 1)
    else $error("hiccup interval wrong");
endmodule
bind bfs_supervisor bfs_supervisor_monitor #(.HICCUP_CYCLES(HICCUP_CYCLES)) u_mon (
  .hclk(hclk), .hresetn(hresetn), .input_low_lockout(input_low_lockout),
  .boot_cap_short(boot_cap_short), .output_overvoltage_guard(output_overvoltage_guard),
  .overtemp_shutdown(overtemp_shutdown), .hs_on(hs_on), .ls_on(ls_on),
  .soft_start_reset(soft_start_reset), .soft_start_active(soft_start_active),
  .hiccup_active(hiccup_active), .power_ok_out_oe(power_ok_out_oe));

// ---- bfs_sync.sv ----
// Two-stage synchroniser for a vector of asynchronous flags
`timescale 1ns/1ps
module bfs_sync #(
  parameter int W = 8
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic [W-1:0] d, // asynchronous flags
  output logic [W-1:0] q // synchronised flags
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bfs_sync_s;

  bfs_sync_s r;
  bfs_sync_s n;

  // First stage feeds only the second stage
  always_comb begin
    n = r;
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign q = r.s2;

endmodule

// ---- bfs_timer.sv ----
// Loadable down timer that flags expiry at zero
`timescale 1ns/1ps
module bfs_timer #(
  parameter int W = 8
) (
  input wire logic hclk, // clock
  input wire logic hresetn, // async reset, active low
  input wire logic ce, // clock enable
  bfs_tmr_if.tmr t // load and expiry
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } bfs_timer_s;

  bfs_timer_s r;
  bfs_timer_s n;

  always_comb begin
    n = r;
    if (t.load) begin
      n.cnt = t.load_val;
    end else if (r.cnt != '0) begin
      n.cnt = r.cnt - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign t.zero = (r.cnt == '0);

endmodule

// ---- bfs_tmr_if.sv ----
// Load and expiry signals between the supervisor and a down timer
`timescale 1ns/1ps
interface bfs_tmr_if #(parameter int W = 8) ();
  logic load;
  logic [W-1:0] load_val;
  logic zero;
  modport ctrl (output load, output load_val, input zero);
  modport tmr (input load, input load_val, output zero);
endinterface

// ---- testbench.sv ----
// Self-checking bench for the buck fault supervisor
`timescale 1ns/1ps
module testbench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, rd_dp, prb, hresp, ce;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic en, in_low, ppl, sec, bopen, bshort, ovv, hot, osc, pwm, vok;
  logic hs, ls, ssr, ssa, hic, pgo, pgoe;
  wire pgw;
  logic [63:0] q[$];
  int n_fail = 0;
  int n_compared = 0;
  wire [1:0] st = hic ? 2'h3 : ssa ? 2'h1 : ssr ? 2'h0 : 2'h2;
  wire [31:0] pins = {25'h0, pgw, pgoe, hic, ssa, ssr, ls, hs};
  assign hready = hreadyout;
  bfs_supervisor #(.HICCUP_CYCLES(20), .SOFT_START_CYCLES(10)) DUT (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .enable_pin(en), .input_low_lockout(in_low),
    .per_pulse_current_limit(ppl), .secondary_current_flag(sec), .boot_cap_open(bopen),
    .boot_cap_short(bshort), .output_overvoltage_guard(ovv), .overtemp_shutdown(hot),
    .pwm_high_req(pwm), .vout_above_uv(vok), .osc_pulse(osc), .hs_on(hs), .ls_on(ls),
    .soft_start_reset(ssr), .soft_start_active(ssa), .hiccup_active(hic),
    .power_ok_out_o(pgo), .power_ok_out_oe(pgoe));
  bfs_partner PM (.hclk(hclk), .hresetn(hresetn), .hs_on(hs), .soft_start_reset(ssr),
    .pg_o(pgo), .pg_oe(pgoe), .osc_pulse(osc), .pwm_high_req(pwm), .vout_above_uv(vok),
    .pg_wire(pgw));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    logic [63:0] e;
    if ((rd_dp && hready) || prb) begin
      e = q.pop_front();
      chk((rd_dp ? hrdata : pins) & e[63:32], e[31:0]);
    end
  end
  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic give_up;
    n_fail++;
    tally_and_finish;
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 || hresp !== 1'b0) begin
      n++;
      if (n > 50) give_up;
      @(posedge hclk);
    end
  endtask
  // For a read, d is the expected word and m the bits compared
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= w;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) begin
      q.push_back({m, d});
      rd_dp <= 1'b1;
    end
    wait_rdy;
    rd_dp <= 1'b0;
  endtask
  task automatic probe(input logic [31:0] m, input logic [31:0] e);
    q.push_back({m, e});
    prb <= 1'b1;
    @(posedge hclk);
    prb <= 1'b0;
    @(posedge hclk);
  endtask
  // Sampled on the falling edge so the registered outputs have settled
  task automatic wait_st(input logic [1:0] s);
    int n;
    n = 0;
    while (st !== s) begin
      @(negedge hclk);
      n++;
      if (n > 3000) give_up;
    end
    @(posedge hclk);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    {hsel, hwrite, rd_dp, prb, in_low, ppl, sec, bopen, bshort, ovv, hot} = '0;
    {ce, en, hresetn, htrans, haddr, hwdata} = {2'h3, 1'b0, 66'h0};
    r = $urandom(84141);
    cyc(16);
    hresetn <= 1'b1;
    bus(0, bfs_pkg::REG_SLOPE, 32'((bfs_pkg::SLOPE_GAIN_MILLI * bfs_pkg::FSW_KHZ) / 1000
        - bfs_pkg::SLOPE_OFFSET_MILLI), '1);
    bus(0, 12'h020, 32'h0, '1);
    wait_st(2'h2);
    probe(32'h7c, 32'h40);
    r = $urandom & ~32'h1;
    bus(1, bfs_pkg::REG_CTRL, r, 32'h0);
    bus(0, bfs_pkg::REG_CTRL, 32'h0, 32'h1);
    cyc(2);
    probe(32'h3f, 32'h24);
    bus(1, bfs_pkg::REG_CTRL, r | 32'h1, 32'h0);
    wait_st(2'h2);
    // Clock enable low: the disable must wait
    ce <= 1'b0;
    en <= 1'b0;
    cyc(8);
    probe(32'h7c, 32'h40);
    ce <= 1'b1;
    cyc(6);
    probe(32'h3f, 32'h24);
    en <= 1'b1;
    wait_st(2'h2);
    in_low <= 1'b1;
    cyc(6 + ($urandom % 4));
    probe(32'h3f, 32'h24);
    bus(0, bfs_pkg::REG_FAULTS, 32'h2, 32'h2);
    in_low <= 1'b0;
    wait_st(2'h2);
    ppl <= 1'b1;
    wait_st(2'h3);
    probe(32'h7d, 32'h34);
    bus(0, bfs_pkg::REG_FAULTS, 32'h80, 32'h80);
    wait_st(2'h1);
    bus(0, bfs_pkg::REG_COUNT, 32'h0, 32'hff);
    wait_st(2'h3);
    ppl <= 1'b0;
    wait_st(2'h2);
    probe(32'h7c, 32'h40);
    bus(1, bfs_pkg::REG_FAULTS, 32'h80, 32'h0);
    bus(0, bfs_pkg::REG_FAULTS, 32'h0, 32'h80);
    ovv <= 1'b1;
    cyc(8);
    probe(32'h21, 32'h0);
    cyc(470);
    probe(32'h20, 32'h0);
    cyc(40);
    probe(32'h20, 32'h20);
    ovv <= 1'b0;
    cyc(10);
    probe(32'h20, 32'h0);
    bopen <= 1'b1;
    wait_st(2'h3);
    probe(32'h7d, 32'h34);
    bopen <= 1'b0;
    wait_st(2'h2);
    probe(32'h7c, 32'h40);
    sec <= 1'b1;
    wait_st(2'h3);
    probe(32'h7f, 32'h34);
    bus(0, bfs_pkg::REG_FAULTS, 32'h40, 32'h40);
    sec <= 1'b0;
    wait_st(2'h2);
    probe(32'h7c, 32'h40);
    hot <= 1'b1;
    cyc(6);
    probe(32'h7f, 32'h24);
    hot <= 1'b0;
    wait_st(2'h2);
    probe(32'h7c, 32'h40);
    bshort <= 1'b1;
    cyc(6);
    probe(32'h7f, 32'h44);
    bshort <= 1'b0;
    cyc(40);
    bus(0, bfs_pkg::REG_STATUS, 32'h4, 32'h7);
    probe(32'h7f, 32'h44);
    // Power cycle with the short still present: no start until it goes
    hresetn <= 1'b0;
    bshort <= 1'b1;
    cyc(3);
    hresetn <= 1'b1;
    cyc(30);
    probe(32'h7f, 32'h44);
    bshort <= 1'b0;
    wait_st(2'h2);
    probe(32'h7c, 32'h40);
    tally_and_finish;
  end
endmodule
